// [verilog/etc_pkg.sv]
// package: register map, field layout and encodings of the endpoint type block
package etc_pkg;
    localparam int unsigned NUM_EP         = 14;
    localparam int unsigned IDX_W          = 4;
    localparam logic [7:0]  OFS_EP_TYPE    = 8'h08;
    localparam logic [7:0]  OFS_EP_INDEX   = 8'h00;
    localparam logic [7:0]  OFS_EP_SIZE    = 8'h04;
    localparam logic [7:0]  OFS_EP_EVENT   = 8'h0c;
    localparam logic [7:0]  OFS_EP_STATUS  = 8'h10;
    localparam int unsigned FLD_KIND_LSB   = 0;
    localparam int unsigned FLD_DBL_BIT    = 2;
    localparam int unsigned FLD_EN_BIT     = 3;
    localparam int unsigned FLD_SUPP_BIT   = 4;
    localparam int unsigned TYPE_W         = 5;
    localparam logic [4:0]  TYPE_RST       = 5'h00;
    localparam int unsigned SIZE_W         = 11;
    localparam logic [10:0] SIZE_RST       = 11'h000;
    localparam int unsigned POOL_BYTES     = 8192;
    localparam int unsigned EVT_DMA_DONE   = 0;
    localparam int unsigned EVT_IN_TOKEN   = 1;
    localparam int unsigned EVT_TOGGLE     = 2;
    localparam int unsigned EVT_BUF_SWAP   = 3;
    typedef enum logic [1:0] {
        ETC_KIND_UNUSED = 2'h0,
        ETC_KIND_ISO    = 2'h1,
        ETC_KIND_BULK   = 2'h2,
        ETC_KIND_INTR   = 2'h3
    } etc_kind_t;
endpackage

// [verilog/etc_ep_slot.sv]
// one endpoint: type settings, toggle, buffer select and zero-length pending
`timescale 1ns/10ps
module etc_ep_slot (
    // clock and reset
    input  wire logic                          clk_sys_i,
    input  wire logic                          rstn_i,
    input  wire logic                          clk_en_i,
    input  wire logic                          usb_reset_i,
    // register write
    input  wire logic                          wr_type_i,
    input  wire logic [etc_pkg::TYPE_W-1:0]    wdata_i,
    input  wire logic                          wr_size_i,
    input  wire logic [etc_pkg::SIZE_W-1:0]    wsize_i,
    // engine events
    input  wire logic                          dma_done_i,
    input  wire logic                          in_token_i,
    input  wire logic                          ack_i,
    // state out
    output logic      [etc_pkg::TYPE_W-1:0]    type_o,
    output logic      [etc_pkg::SIZE_W-1:0]    size_o,
    output logic                               toggle_o,
    output logic                               buf_sel_o,
    output logic                               zlp_pend_o
);
    typedef struct packed {
        logic [etc_pkg::TYPE_W-1:0] cfg;
        logic [etc_pkg::SIZE_W-1:0] size;
        logic                       toggle;
        logic                       buf_sel;
        logic                       zlp;
    } etc_slot_t;

    etc_slot_t s_q, s_d;
    logic      en_now;
    logic      en_next;

    assign en_now  = s_q.cfg[etc_pkg::FLD_EN_BIT];
    assign en_next = wdata_i[etc_pkg::FLD_EN_BIT];

    // next-state of the endpoint slot
    always_comb begin
        s_d = s_q;
        if (wr_size_i) begin
            s_d.size = wsize_i;
        end
        if (en_now && ack_i) begin
            s_d.toggle = ~s_q.toggle; // toggle keeps running across stall
            if (s_q.cfg[etc_pkg::FLD_DBL_BIT]) begin
                s_d.buf_sel = ~s_q.buf_sel; // alternate buffers
            end else begin
                s_d.buf_sel = 1'b0; // single buffer
            end
        end
        if (en_now && dma_done_i && !s_q.cfg[etc_pkg::FLD_SUPP_BIT]) begin
            s_d.zlp = 1'b1; // closing empty packet armed
        end else if (in_token_i) begin
            s_d.zlp = 1'b0; // answered by the next in token
        end
        if (s_q.cfg[etc_pkg::FLD_SUPP_BIT]) begin
            s_d.zlp = 1'b0; // no closing empty packet
        end
        if (wr_type_i) begin
            s_d.cfg = wdata_i;
            if (!en_next) begin
                s_d.toggle  = 1'b0; // disable resets toggle pid
                s_d.buf_sel = 1'b0;
                s_d.zlp     = 1'b0; // disabled fifo idles
            end
            if (!wdata_i[etc_pkg::FLD_DBL_BIT]) begin
                s_d.buf_sel = 1'b0;
            end
        end
        if (usb_reset_i) begin
            s_d.cfg     = etc_pkg::TYPE_RST; // bus reset clears settings
            s_d.size    = etc_pkg::SIZE_RST;
            s_d.toggle  = 1'b0;
            s_d.buf_sel = 1'b0;
            s_d.zlp     = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0; // power-on clears settings
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    assign type_o     = s_q.cfg;
    assign size_o     = s_q.size;
    assign toggle_o   = s_q.toggle;
    assign buf_sel_o  = s_q.buf_sel;
    assign zlp_pend_o = s_q.zlp;
endmodule

// [verilog/etc_top.sv]
// top: apb register bank for indexed endpoint type settings and endpoint controls
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module etc_top #(
    parameter int unsigned NUM_EP = etc_pkg::NUM_EP
) (
    // clock, enable, reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      rstn_i,
    input  wire logic                      clk_en_i,
    input  wire logic                      usb_reset_i,
    // apb slave
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [7:0]                paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    // engine event strobes for the endpoint given on ev_ep_i
    input  wire logic [etc_pkg::IDX_W-1:0] ev_ep_i,
    input  wire logic                      dma_done_i,
    input  wire logic                      in_token_i,
    input  wire logic                      ack_i,
    // per-endpoint controls and pool tally
    output logic      [NUM_EP-1:0]         ep_active_o,
    output logic      [NUM_EP-1:0]         ep_iso_o,
    output logic      [NUM_EP-1:0]         ep_bulk_o,
    output logic      [NUM_EP-1:0]         ep_intr_o,
    output logic      [NUM_EP-1:0]         ep_dbl_o,
    output logic      [NUM_EP-1:0]         ep_toggle_o,
    output logic      [NUM_EP-1:0]         ep_buf_sel_o,
    output logic      [NUM_EP-1:0]         ep_send_zlp_o,
    output logic      [13:0]               pool_used_o,
    output logic                           pool_over_o
);
    typedef struct packed {
        logic [31:0]               rdata;
        logic                      ready;
        logic                      err;
        logic [etc_pkg::IDX_W-1:0] index;
        logic [NUM_EP-1:0]         active;
        logic [NUM_EP-1:0]         iso;
        logic [NUM_EP-1:0]         bulk;
        logic [NUM_EP-1:0]         intr;
        logic [NUM_EP-1:0]         dbl;
        logic [NUM_EP-1:0]         tog;
        logic [NUM_EP-1:0]         bsel;
        logic [NUM_EP-1:0]         zlp;
        logic [13:0]               used;
        logic                      over;
    } etc_top_t;

    etc_top_t r_q, r_d;

    logic                       acc;
    logic                       idx_ok;
    logic [NUM_EP-1:0]          wr_type;
    logic [NUM_EP-1:0]          wr_size;
    logic [etc_pkg::TYPE_W-1:0] slot_type [NUM_EP];
    logic [etc_pkg::SIZE_W-1:0] slot_size [NUM_EP];
    logic [NUM_EP-1:0]          slot_tog;
    logic [NUM_EP-1:0]          slot_bsel;
    logic [NUM_EP-1:0]          slot_zlp;

    // a write or read completes one cycle after the access cycle begins, with one wait state
    assign acc    = psel_i && penable_i && !r_q.ready;
    assign idx_ok = (32'(r_q.index) < NUM_EP);

    // per-endpoint write strobes through the index
    always_comb begin
        wr_type = '0;
        wr_size = '0;
        for (int i = 0; i < NUM_EP; i++) begin
            if (acc && pwrite_i && idx_ok && r_q.index == etc_pkg::IDX_W'(i)) begin
                wr_type[i] = (paddr_i == etc_pkg::OFS_EP_TYPE);
                wr_size[i] = (paddr_i == etc_pkg::OFS_EP_SIZE);
            end
        end
    end

    // endpoint slots
    for (genvar g = 0; g < NUM_EP; g++) begin : g_slot
        logic hit;
        assign hit = (ev_ep_i == etc_pkg::IDX_W'(g));
        etc_ep_slot u_slot (
            .clk_sys_i  (clk_sys_i),
            .rstn_i     (rstn_i),
            .clk_en_i   (clk_en_i),
            .usb_reset_i(usb_reset_i),
            .wr_type_i  (wr_type[g]),
            .wdata_i    (pwdata_i[etc_pkg::TYPE_W-1:0]), // bits 31:5 dropped
            .wr_size_i  (wr_size[g]),
            .wsize_i    (pwdata_i[etc_pkg::SIZE_W-1:0]),
            .dma_done_i (dma_done_i && hit),
            .in_token_i (in_token_i && hit),
            .ack_i      (ack_i && hit),
            .type_o     (slot_type[g]),
            .size_o     (slot_size[g]),
            .toggle_o   (slot_tog[g]),
            .buf_sel_o  (slot_bsel[g]),
            .zlp_pend_o (slot_zlp[g])
        );
    end

    // bus answer, index register and decoded endpoint controls
    always_comb begin
        logic [16:0] sum; // wide enough for every endpoint double buffered
        logic [1:0]  kind;
        logic        en;
        sum = '0;
        kind = '0;
        en = 1'b0;
        r_d = r_q;
        r_d.ready = acc;
        r_d.err   = 1'b0;
        if (acc) begin
            r_d.rdata = '0;
            unique case (paddr_i)
                etc_pkg::OFS_EP_INDEX: begin
                    if (pwrite_i) begin
                        r_d.index = pwdata_i[etc_pkg::IDX_W-1:0];
                    end
                    r_d.rdata = {28'h0, r_q.index};
                end
                etc_pkg::OFS_EP_TYPE: begin
                    if (idx_ok) begin
                        r_d.rdata = {27'h0, slot_type[r_q.index]}; // reserved reads 0
                    end
                end
                etc_pkg::OFS_EP_SIZE: begin
                    if (idx_ok) begin
                        r_d.rdata = {21'h0, slot_size[r_q.index]};
                    end
                end
                etc_pkg::OFS_EP_STATUS: begin
                    if (idx_ok) begin
                        r_d.rdata = {29'h0, slot_zlp[r_q.index], slot_bsel[r_q.index],
                                     slot_tog[r_q.index]};
                    end
                end
                default: begin
                    r_d.err = 1'b1; // unmapped address
                end
            endcase
        end
        // decode every endpoint and tally the reserved pool
        for (int i = 0; i < NUM_EP; i++) begin
            kind = slot_type[i][etc_pkg::FLD_KIND_LSB +: 2];
            en   = slot_type[i][etc_pkg::FLD_EN_BIT];
            r_d.active[i] = en && (kind != etc_pkg::ETC_KIND_UNUSED);
            r_d.iso[i]  = en && (kind == etc_pkg::ETC_KIND_ISO);
            r_d.bulk[i] = en && (kind == etc_pkg::ETC_KIND_BULK);
            r_d.intr[i] = en && (kind == etc_pkg::ETC_KIND_INTR);
            r_d.dbl[i]  = en && slot_type[i][etc_pkg::FLD_DBL_BIT];
            r_d.tog[i]  = slot_tog[i];
            r_d.bsel[i] = slot_bsel[i] && r_d.dbl[i];
            r_d.zlp[i]  = en && slot_zlp[i];
            if (en) begin
                sum = sum + (r_d.dbl[i] ? {5'h0, slot_size[i], 1'b0}
                                        : {6'h0, slot_size[i]}); // memory reserved
            end
        end
        r_d.used = (sum > 17'h03fff) ? 14'h3fff : sum[13:0]; // saturate the reported tally
        r_d.over = (32'(sum) > etc_pkg::POOL_BYTES); // firmware must avoid this
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_q <= '0;
        end else if (clk_en_i) begin
            r_q <= r_d;
        end
    end

    assign prdata_o      = r_q.rdata;
    assign pready_o      = r_q.ready;
    assign pslverr_o     = r_q.err;
    assign ep_active_o   = r_q.active;
    assign ep_iso_o      = r_q.iso;
    assign ep_bulk_o     = r_q.bulk;
    assign ep_intr_o     = r_q.intr;
    assign ep_dbl_o      = r_q.dbl;
    assign ep_toggle_o   = r_q.tog;
    assign ep_buf_sel_o  = r_q.bsel;
    assign ep_send_zlp_o = r_q.zlp;
    assign pool_used_o   = r_q.used;
    assign pool_over_o   = r_q.over;
endmodule

// [testbench/etc_props.sv]
// checker: temporal properties on the endpoint type block ports
`timescale 1ns/10ps
module etc_props #(
    parameter int unsigned NUM_EP = etc_pkg::NUM_EP
) (
    // clock and reset
    input wire logic                      clk_sys_i,
    input wire logic                      rstn_i,
    input wire logic                      clk_en_i,
    input wire logic                      usb_reset_i,
    // apb
    input wire logic                      psel_i,
    input wire logic                      penable_i,
    input wire logic [7:0]                paddr_i,
    input wire logic                      pready_o,
    input wire logic                      pslverr_o,
    // events and endpoint controls
    input wire logic [etc_pkg::IDX_W-1:0] ev_ep_i,
    input wire logic                      dma_done_i,
    input wire logic                      in_token_i,
    input wire logic                      ack_i,
    input wire logic [NUM_EP-1:0]         ep_active_o,
    input wire logic [NUM_EP-1:0]         ep_iso_o,
    input wire logic [NUM_EP-1:0]         ep_bulk_o,
    input wire logic [NUM_EP-1:0]         ep_intr_o,
    input wire logic [NUM_EP-1:0]         ep_dbl_o,
    input wire logic [NUM_EP-1:0]         ep_toggle_o,
    input wire logic [NUM_EP-1:0]         ep_buf_sel_o,
    input wire logic [NUM_EP-1:0]         ep_send_zlp_o
);
    logic acc;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // access cycle still waiting for its answer
    assign acc = psel_i && penable_i && !pready_o && clk_en_i;

    pready_wait_a: assert property (acc |=> pready_o) else $error("no ready after access");
    pready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
    slverr_map_a: assert property (acc |=> pslverr_o == !($past(paddr_i) inside
        {8'h00, 8'h04, 8'h08, 8'h10})) else $error("wrong slave error");
    kind_gate_a: assert property ((ep_iso_o | ep_bulk_o | ep_intr_o) == ep_active_o)
        else $error("kind decode not gated");
    kind_onehot_a: assert property (((ep_iso_o & ep_bulk_o) | (ep_iso_o & ep_intr_o)
        | (ep_bulk_o & ep_intr_o)) == '0) else $error("two kinds at once");
    buf_single_a: assert property ((ep_buf_sel_o & ~ep_dbl_o) == '0)
        else $error("second buffer on single");
    toggle_flip_a: assert property (ack_i && clk_en_i && ep_active_o[ev_ep_i]
        |-> ##3 ep_toggle_o[$past(ev_ep_i, 3)] != $past(ep_toggle_o[ev_ep_i], 3))
        else $error("toggle did not flip");
    zlp_clear_a: assert property (in_token_i && !dma_done_i && clk_en_i
        |-> ##3 !ep_send_zlp_o[$past(ev_ep_i, 3)]) else $error("empty packet kept");
    usb_clear_a: assert property (usb_reset_i && clk_en_i |-> ##3
        (ep_active_o == '0 && ep_toggle_o == '0 && ep_send_zlp_o == '0))
        else $error("bus reset left state");

    // main scenarios
    cover property (acc ##1 pslverr_o);
    cover property (ack_i && ep_dbl_o[ev_ep_i]);
    cover property (dma_done_i ##3 ep_send_zlp_o != '0);
endmodule

// [testbench/etc_engine_model.sv]
// partner: transaction engine model issuing one-cycle event strobes
`timescale 1ns/10ps
module etc_engine_model (
    // clock
    input  wire logic       clk_sys_i,
    // event strobes
    output logic      [3:0] ev_ep_o,
    output logic            dma_done_o,
    output logic            in_token_o,
    output logic            ack_o
);
    // idle: strobes low, endpoint number not held
    initial begin
        ev_ep_o = 4'hf;
        {ack_o, in_token_o, dma_done_o} = 3'h0;
    end

    // k is {ack, in token, dma done}; idle number is the inverse of the last
    task fire(input logic [2:0] k, input logic [3:0] ep);
        ev_ep_o <= ep;
        {ack_o, in_token_o, dma_done_o} <= k;
        @(posedge clk_sys_i);
        ev_ep_o <= ~ep;
        {ack_o, in_token_o, dma_done_o} <= 3'h0;
    endtask
endmodule

// [testbench/etc_top_tb_top.sv]
// testbench: apb register scenarios and engine events for the endpoint type block
`timescale 1ns/10ps
module etc_top_tb_top;
    logic        clk_sys_i = 1'b0, rstn_i = 1'b0, clk_en_i = 1'b1, usb_reset_i = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, rd, prdata_o;
    logic        pready_o, pslverr_o, err, dma_done_i, in_token_i, ack_i, pool_over_o;
    logic [3:0]  ev_ep_i;
    logic [13:0] ep_active_o, ep_iso_o, ep_bulk_o, ep_intr_o, ep_dbl_o, ep_toggle_o;
    logic [13:0] ep_buf_sel_o, ep_send_zlp_o, pool_used_o;
    int          n_mismatch = 0, compares = 0;

    // 50 MHz clock
    always #10 clk_sys_i = ~clk_sys_i;

    etc_top #(.NUM_EP(14)) etc_top_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .clk_en_i(clk_en_i), .usb_reset_i(usb_reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ev_ep_i(ev_ep_i),
        .dma_done_i(dma_done_i), .in_token_i(in_token_i), .ack_i(ack_i),
        .ep_active_o(ep_active_o), .ep_iso_o(ep_iso_o), .ep_bulk_o(ep_bulk_o),
        .ep_intr_o(ep_intr_o), .ep_dbl_o(ep_dbl_o), .ep_toggle_o(ep_toggle_o),
        .ep_buf_sel_o(ep_buf_sel_o), .ep_send_zlp_o(ep_send_zlp_o),
        .pool_used_o(pool_used_o), .pool_over_o(pool_over_o));
    etc_engine_model etc_engine_model_i (.clk_sys_i(clk_sys_i), .ev_ep_o(ev_ep_i),
        .dma_done_o(dma_done_i), .in_token_o(in_token_i), .ack_o(ack_i));

    // comparison, verdict and bus tasks
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task end_sim;
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_mismatch++;
            end_sim();
        end else begin
            rd = prdata_o;
            err = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    task ev(input logic [2:0] k, input logic [3:0] ep);
        etc_engine_model_i.fire(k, ep);
        repeat (4) @(posedge clk_sys_i);
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        chk("active", 32'(ep_active_o), 32'h0);
        rchk("type rst", 8'h08, 32'h0);
        for (int k = 1; k < 4; k++) begin
            apb(1'b1, 8'h00, 32'(k));
            apb(1'b1, 8'h04, 32'(64 * k));
            apb(1'b1, 8'h08, (k == 2) ? 32'h0e : 32'(8 + k));
            rchk("type", 8'h08, (k == 2) ? 32'h0e : 32'(8 + k));
        end
        chk("iso", 32'(ep_iso_o), 32'h2);
        chk("bulk", 32'(ep_bulk_o), 32'h4);
        chk("intr", 32'(ep_intr_o), 32'h8);
        chk("dbl", 32'(ep_dbl_o), 32'h4);
        chk("pool", 32'(pool_used_o), 32'h200);
        apb(1'b1, 8'h00, 32'h4);
        apb(1'b1, 8'h08, 32'hffff_ffe3);
        rchk("reserved", 8'h08, 32'h3);
        apb(1'b1, 8'h00, 32'h2);
        ev(3'h4, 4'h2);
        chk("bsel", 32'(ep_buf_sel_o), 32'h4);
        rchk("stat dbl", 8'h10, 32'h3);
        apb(1'b1, 8'h08, 32'h06);
        rchk("stat off", 8'h10, 32'h0);
        chk("off", 32'(ep_active_o), 32'ha);
        chk("pool off", 32'(pool_used_o), 32'h100);
        apb(1'b1, 8'h08, 32'h0e);
        rchk("stat on", 8'h10, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        ev(3'h4, 4'h1);
        rchk("stat single", 8'h10, 32'h1);
        ev(3'h1, 4'h1);
        chk("zlp armed", 32'(ep_send_zlp_o), 32'h2);
        ev(3'h2, 4'h1);
        chk("zlp sent", 32'(ep_send_zlp_o), 32'h0);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h08, 32'h1b);
        ev(3'h1, 4'h3);
        chk("zlp supp", 32'(ep_send_zlp_o), 32'h0);
        // an ack while the clock enable is low is lost
        clk_en_i <= 1'b0;
        etc_engine_model_i.fire(3'h4, 4'h1);
        repeat (2) @(posedge clk_sys_i);
        clk_en_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        chk("frozen", 32'(ep_toggle_o), 32'h2);
        // two large double-buffered endpoints push the pool past its limit
        apb(1'b1, 8'h04, 32'h7ff);
        apb(1'b1, 8'h08, 32'h0e);
        apb(1'b1, 8'h00, 32'h4);
        apb(1'b1, 8'h04, 32'h7ff);
        apb(1'b1, 8'h08, 32'h0e);
        repeat (2) @(posedge clk_sys_i);
        chk("pool full", 32'(pool_used_o), 32'h213c);
        chk("pool over", 32'(pool_over_o), 32'h1);
        usb_reset_i <= 1'b1;
        @(posedge clk_sys_i);
        usb_reset_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk("bus rst", 32'(ep_active_o), 32'h0);
        chk("pool clr", 32'(pool_over_o), 32'h0);
        rchk("type bus rst", 8'h08, 32'h0);
        // a second power-on reset also clears the index left by the bus reset
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        rchk("index por", 8'h00, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'(err), 32'h1);
        end_sim();
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        end_sim();
    end
endmodule

bind etc_top etc_props #(.NUM_EP(NUM_EP)) etc_props_i (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .clk_en_i(clk_en_i), .usb_reset_i(usb_reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ev_ep_i(ev_ep_i), .dma_done_i(dma_done_i), .in_token_i(in_token_i), .ack_i(ack_i),
    .ep_active_o(ep_active_o), .ep_iso_o(ep_iso_o), .ep_bulk_o(ep_bulk_o),
    .ep_intr_o(ep_intr_o), .ep_dbl_o(ep_dbl_o), .ep_toggle_o(ep_toggle_o),
    .ep_buf_sel_o(ep_buf_sel_o), .ep_send_zlp_o(ep_send_zlp_o));
